// file: blcd_fabric_model.sv
`timescale 1ns/100ps
`default_nettype none
module blcd_fabric_model
  import blcd_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic [NUM_TICKS-1:0] src_mask,
  input  wire logic                 fire,
  input  wire logic                 clr,
  input  wire logic                 fabric_clk_tick,
  output var  logic [NUM_TICKS-1:0] src_lvl,
  output var  logic [7:0]           fab_cnt
);
  // ****************************************************************
  // source clocks and fabric capture
  // ****************************************************************
  int phase;

  initial begin
    src_lvl = '0;
    fab_cnt = 8'h00;
    phase   = 0;
  end

  // clocks stand still low outside a burst; 3 high, 3 low keeps every edge
  always @(posedge core_clk) begin
    phase   <= (!fire || phase == 5) ? 0 : phase + 1;
    src_lvl <= (fire && phase < 3) ? src_mask : '0;
    fab_cnt <= clr ? 8'h00 : fab_cnt + {7'h00, fabric_clk_tick};
  end
endmodule : blcd_fabric_model
`default_nettype wire

// file: blcd_pkg.sv
`default_nettype none
package blcd_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int NUM_LANES  = 4;
  localparam int X2_LANES   = 2;
  localparam int NUM_TICKS  = 3 + 2 * NUM_LANES;
  localparam int PTR_W      = 3;

  // ****************************************************************
  // tick vector positions
  // ****************************************************************
  localparam int TICK_PLL_A = 0;
  localparam int TICK_PLL_B = 1;
  localparam int TICK_GEN   = 2;
  localparam int TICK_REC_LS = 3;
  localparam int TICK_REC_HS = 3 + NUM_LANES;

  // ****************************************************************
  // reset values and increments
  // ****************************************************************
  localparam logic [PTR_W-1:0] PTR_RST = 3'h0;
  localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;

  // ****************************************************************
  // modes
  // ****************************************************************
  typedef enum logic [1:0] {
    BLCD_BOND_NONE,
    BLCD_BOND_X2,
    BLCD_BOND_X4
  } blcd_bond_t;

  typedef enum logic [1:0] {
    BLCD_OP_TX_ONLY,
    BLCD_OP_RX_ONLY,
    BLCD_OP_TX_RX
  } blcd_op_t;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    blcd_bond_t           bond;
    blcd_op_t             op;
    logic                 rate_match;
    logic                 byte_ser;
    logic                 byte_deser;
    logic                 shared_sel;
    logic                 alt_src;
    logic [NUM_LANES-1:0] hs_sel;
    logic [NUM_LANES-1:0] lane_ls_sel;
  } blcd_cfg_t;

  typedef struct packed {
    logic ser_hs;
    logic enc;
    logic bser_rd;
    logic txf_rd;
    logic deser_hs;
    logic wa;
    logic rmf_wr;
    logic rmf_rd;
    logic dec;
    logic bdes_wr;
    logic bord;
    logic rxf_wr;
  } blcd_lane_clk_t;

  typedef struct packed {
    logic                             shared_div;
    logic [NUM_LANES-1:0]             tx_div;
    logic [NUM_LANES-1:0]             rx_div;
    logic [PTR_W-1:0]                 shared_ptr;
    logic [NUM_LANES-1:0][PTR_W-1:0]  lane_ptr;
    blcd_bond_t                       bond_prev;
    blcd_lane_clk_t [NUM_LANES-1:0]   clk;
    logic                             fabric_tick;
  } blcd_state_t;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic pulse;
  } blcd_sync_state_t;

  localparam blcd_state_t      STATE_RST = '0;
  localparam blcd_sync_state_t SYNC_RST  = '0;

endpackage : blcd_pkg
`default_nettype wire

// file: blcd_tick_sync.sv
`timescale 1ns/100ps
`default_nettype none
module blcd_tick_sync
  import blcd_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic async_in,
  output var  logic pulse
);

  blcd_sync_state_t st_reg;
  blcd_sync_state_t st_next;

  // ****************************************************************
  // two-flop crossing, then rising-edge strobe
  // ****************************************************************
  // meta is read only by sync so the edge detector never sees it
  always_comb begin
    st_next       = st_reg;
    st_next.meta  = async_in;
    st_next.sync  = st_reg.meta;
    st_next.last  = st_reg.sync;
    st_next.pulse = st_reg.sync & ~st_reg.last;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg <= SYNC_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse = st_reg.pulse;

endmodule : blcd_tick_sync
`default_nettype wire

// file: blcd_top.sv
// Summary of operation
// - bonded lanes take their low-speed strobe from one shared path
// - bonded lanes share one fifo pointer, so latency matches
// - each lane picks its own high-speed source for its serializer
// - shared path picks between the two adjacent plls
// - in two-lane bonding, lanes 2 and 3 run on their own
// - two-lane groups may use the general pll as source
// - encoder, serializer read and tx fifo read use the shared strobe
// - byte serializer on halves the tx fifo read strobe
// - shared strobe is exported as the bonded fabric clock
// - receive-only operation never bonds
// - bonded tx-rx works with and without rate matching
// - recovered high-speed strobe drives each lane deserializer
// - rate matching: aligner and rm fifo write use lane recovered strobe
// - rate matching: rest of receive path uses the shared strobe
// - byte deserializer on halves the rx fifo write strobe
// - no rate matching: tx as bonded, rx as non-bonded lanes
// - no rate matching: non-bonded rx path runs on its own recovered strobe
`timescale 1ns/100ps
`default_nettype none
module blcd_top
  import blcd_pkg::*;
(
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  input  wire blcd_cfg_t                       cfg,
  input  wire logic                            adjacent_pll_a,
  input  wire logic                            adjacent_pll_b,
  input  wire logic                            general_pll_one,
  input  wire logic [NUM_LANES-1:0]            rec_ls_clk,
  input  wire logic [NUM_LANES-1:0]            rec_hs_clk,
  output var  blcd_lane_clk_t [NUM_LANES-1:0]  lane_clk,
  output var  logic [NUM_LANES-1:0][PTR_W-1:0] lane_fifo_ptr,
  output var  logic                            fabric_clk_tick
);

  blcd_state_t          st_reg;
  blcd_state_t          st_next;
  logic [NUM_TICKS-1:0] tick_raw;
  logic [NUM_TICKS-1:0] tick;
  logic                 pa;
  logic                 pb;
  logic                 pg;

  // ****************************************************************
  // input crossings
  // ****************************************************************
  assign tick_raw = {rec_hs_clk, rec_ls_clk, general_pll_one, adjacent_pll_b, adjacent_pll_a};

  for (genvar g = 0; g < NUM_TICKS; g++) begin : g_sync
    blcd_tick_sync u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .async_in (tick_raw[g]),
      .pulse    (tick[g])
    );
  end

  assign pa = tick[TICK_PLL_A];
  assign pb = tick[TICK_PLL_B];
  assign pg = tick[TICK_GEN];

  // ****************************************************************
  // distribution
  // ****************************************************************
  blcd_bond_t eff_bond;
  logic       rm;
  logic       has_tx;
  logic       has_rx;
  logic       shared_ls;
  logic       shared_half;
  logic       shared_txf;

  always_comb begin
    logic bonded;
    logic own_ls;
    logic own_half;
    logic rec_ls;
    logic rec_half;
    logic hs;
    logic tx_ls;
    logic tx_half;
    logic rx_c;
    logic rx_h;
    bonded   = 1'b0;
    own_ls   = 1'b0;
    own_half = 1'b0;
    rec_ls   = 1'b0;
    rec_half = 1'b0;
    hs       = 1'b0;
    tx_ls    = 1'b0;
    tx_half  = 1'b0;
    rx_c     = 1'b0;
    rx_h     = 1'b0;
    st_next  = st_reg;
    // receive-only lanes run on recovered clocks alone
    eff_bond = (cfg.op == BLCD_OP_RX_ONLY) ? BLCD_BOND_NONE : cfg.bond;
    rm       = cfg.rate_match && (cfg.op == BLCD_OP_TX_RX);
    has_tx   = (cfg.op != BLCD_OP_RX_ONLY);
    has_rx   = (cfg.op != BLCD_OP_TX_ONLY);
    shared_ls = cfg.shared_sel ? pb :
                ((eff_bond == BLCD_BOND_X2 && cfg.alt_src) ? pg : pa);
    shared_half = shared_ls & st_reg.shared_div;
    st_next.shared_div = st_reg.shared_div ^ shared_ls;
    shared_txf = has_tx & (cfg.byte_ser ? shared_half : shared_ls);
    st_next.bond_prev = eff_bond;
    // one pointer for every bonded lane; restart on any regrouping
    if (eff_bond != st_reg.bond_prev) begin
      st_next.shared_ptr = PTR_RST;
    end else if (shared_txf) begin
      st_next.shared_ptr = st_reg.shared_ptr + PTR_ONE;
    end
    st_next.fabric_tick = (eff_bond != BLCD_BOND_NONE) & shared_ls;
    for (int i = 0; i < NUM_LANES; i++) begin
      unique case (eff_bond)
        BLCD_BOND_NONE: bonded = 1'b0;
        BLCD_BOND_X2:   bonded = (i < X2_LANES);
        BLCD_BOND_X4:   bonded = 1'b1;
        default:        bonded = 1'b0;
      endcase
      own_ls   = cfg.lane_ls_sel[i] ? pb : pa;
      own_half = own_ls & st_reg.tx_div[i];
      st_next.tx_div[i] = st_reg.tx_div[i] ^ own_ls;
      rec_ls   = tick[TICK_REC_LS + i];
      rec_half = rec_ls & st_reg.rx_div[i];
      st_next.rx_div[i] = st_reg.rx_div[i] ^ rec_ls;
      hs = cfg.hs_sel[i] ? pb :
           ((bonded && eff_bond == BLCD_BOND_X2 && cfg.alt_src) ? pg : pa);
      tx_ls   = bonded ? shared_ls : own_ls;
      tx_half = bonded ? shared_half : own_half;
      // without rate matching the receive side never touches tx strobes
      rx_c = rm ? tx_ls : rec_ls;
      rx_h = rm ? tx_half : rec_half;
      st_next.clk[i].ser_hs   = has_tx & hs;
      st_next.clk[i].enc      = has_tx & tx_ls;
      st_next.clk[i].bser_rd  = has_tx & tx_ls;
      st_next.clk[i].txf_rd   = has_tx & (cfg.byte_ser ? tx_half : tx_ls);
      st_next.clk[i].deser_hs = has_rx & tick[TICK_REC_HS + i];
      st_next.clk[i].wa       = has_rx & rec_ls;
      st_next.clk[i].rmf_wr   = has_rx & rm & rec_ls;
      st_next.clk[i].rmf_rd   = has_rx & rm & tx_ls;
      st_next.clk[i].dec      = has_rx & rx_c;
      st_next.clk[i].bdes_wr  = has_rx & rx_c;
      st_next.clk[i].bord     = has_rx & rx_c;
      st_next.clk[i].rxf_wr   = has_rx & (cfg.byte_deser ? rx_h : rx_c);
      if (bonded) begin
        st_next.lane_ptr[i] = st_next.shared_ptr;
      end else if (st_next.clk[i].txf_rd) begin
        st_next.lane_ptr[i] = st_reg.lane_ptr[i] + PTR_ONE;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg <= STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lane_clk        = st_reg.clk;
  assign lane_fifo_ptr   = st_reg.lane_ptr;
  assign fabric_clk_tick = st_reg.fabric_tick;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_SHARED_LS: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X4 |->
      lane_clk[0].enc == fabric_clk_tick && lane_clk[3].enc == fabric_clk_tick)
    else $error("bonded lane encoder strobe differs from shared strobe");

  AST_PTR_EQUAL: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X4 |->
      lane_fifo_ptr[1] == lane_fifo_ptr[0] && lane_fifo_ptr[3] == lane_fifo_ptr[0])
    else $error("bonded lane fifo pointers differ");

  AST_HS_SEL: assert property (@(posedge core_clk) disable iff (reset)
    $past(cfg.hs_sel[2]) && $past(cfg.op) != BLCD_OP_RX_ONLY |->
      lane_clk[2].ser_hs == $past(pb))
    else $error("lane high-speed strobe not from selected pll");

  AST_SHARED_SEL: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X4 && $past(cfg.shared_sel) |->
      fabric_clk_tick == $past(pb))
    else $error("shared path not from selected pll");

  AST_X2_FREE: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X2 && !$past(cfg.lane_ls_sel[3]) |->
      lane_clk[3].enc == $past(pa))
    else $error("lane 3 not independent in two-lane bonding");

  AST_ALT_SRC: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X2 && $past(cfg.alt_src) && !$past(cfg.shared_sel) |->
      fabric_clk_tick == $past(pg))
    else $error("two-lane group ignores general pll");

  AST_HALF_TX: assert property (@(posedge core_clk) disable iff (reset)
    lane_clk[0].txf_rd && $past(cfg.byte_ser) |->
      lane_clk[0].enc ##1 !lane_clk[0].txf_rd)
    else $error("tx fifo read strobe not halved");

  AST_RX_ONLY: assert property (@(posedge core_clk) disable iff (reset)
    $past(cfg.op) == BLCD_OP_RX_ONLY |-> !fabric_clk_tick && st_reg.bond_prev == BLCD_BOND_NONE)
    else $error("receive-only operation bonded");

  AST_RM_SPLIT: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X4 && $past(cfg.rate_match) && $past(cfg.op) == BLCD_OP_TX_RX
      |-> lane_clk[1].rmf_rd == fabric_clk_tick && lane_clk[1].dec == fabric_clk_tick
          && lane_clk[1].wa == $past(tick[TICK_REC_LS + 1]))
    else $error("rate-match receive clocking wrong");

  AST_NO_RM: assert property (@(posedge core_clk) disable iff (reset)
    !$past(cfg.rate_match) && $past(cfg.op) == BLCD_OP_TX_RX |->
      lane_clk[0].dec == lane_clk[0].wa && !lane_clk[0].rmf_rd)
    else $error("receive lane without rate matching not on recovered strobe");

  AST_PTR_RESTART: assert property (@(posedge core_clk) disable iff (reset)
    st_next.bond_prev != st_reg.bond_prev |=> st_reg.shared_ptr == PTR_RST)
    else $error("shared pointer not restarted on regrouping");

  AST_BSER_SHARED: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev != BLCD_BOND_NONE |->
      lane_clk[0].bser_rd == fabric_clk_tick && lane_clk[1].bser_rd == fabric_clk_tick)
    else $error("bonded serializer read strobe differs from shared strobe");

  AST_TXF_FULL: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev != BLCD_BOND_NONE && !$past(cfg.byte_ser) |->
      lane_clk[1].txf_rd == fabric_clk_tick)
    else $error("bonded tx fifo read strobe differs from shared strobe");

  AST_HALF_RX: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X4 && $past(cfg.byte_ser) && $past(cfg.byte_deser)
      && $past(cfg.rate_match) && $past(cfg.op) == BLCD_OP_TX_RX |->
      lane_clk[2].rxf_wr == lane_clk[2].txf_rd)
    else $error("halved rx fifo write strobe not on the shared divider");

  AST_DESER_HS: assert property (@(posedge core_clk) disable iff (reset)
    $past(cfg.op) != BLCD_OP_TX_ONLY |->
      lane_clk[3].deser_hs == $past(tick[TICK_REC_HS + 3]))
    else $error("deserializer strobe not from recovered high-speed clock");

  AST_RX_ONLY_TX: assert property (@(posedge core_clk) disable iff (reset)
    $past(cfg.op) == BLCD_OP_RX_ONLY |->
      !lane_clk[0].enc && !lane_clk[2].txf_rd && !lane_clk[3].ser_hs)
    else $error("transmit strobe active in receive-only operation");

  AST_RM_WR: assert property (@(posedge core_clk) disable iff (reset)
    $past(cfg.rate_match) && $past(cfg.op) == BLCD_OP_TX_RX |->
      lane_clk[3].rmf_wr == $past(tick[TICK_REC_LS + 3])
      && lane_clk[3].wa == lane_clk[3].rmf_wr)
    else $error("rate-match fifo write not on lane recovered strobe");

  AST_RM_OFF: assert property (@(posedge core_clk) disable iff (reset)
    !($past(cfg.rate_match) && $past(cfg.op) == BLCD_OP_TX_RX) |->
      !lane_clk[2].rmf_wr && !lane_clk[2].rmf_rd)
    else $error("rate-match fifo strobe active without rate matching");

  AST_X2_PTR: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X2 |->
      lane_fifo_ptr[1] == lane_fifo_ptr[0])
    else $error("two-lane group fifo pointers differ");

  AST_X2_HS_ALT: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X2 && $past(cfg.alt_src) && !$past(cfg.hs_sel[1]) |->
      lane_clk[1].ser_hs == $past(pg))
    else $error("two-lane group high-speed strobe ignores general pll");

  AST_X2_FREE_HS: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X2 && !$past(cfg.hs_sel[2]) |->
      lane_clk[2].ser_hs == $past(pa))
    else $error("lane 2 high-speed strobe not independent in two-lane bonding");

  AST_NO_BOND_FAB: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_NONE |-> !fabric_clk_tick)
    else $error("fabric clock strobe without bonding");

  AST_X4_FAB: assert property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X4 && !$past(cfg.shared_sel) |->
      fabric_clk_tick == $past(pa))
    else $error("shared path not from first adjacent pll");

  AST_RX_OWN: assert property (@(posedge core_clk) disable iff (reset)
    !($past(cfg.rate_match) && $past(cfg.op) == BLCD_OP_TX_RX)
      && !$past(cfg.byte_deser) |->
      lane_clk[2].rxf_wr == lane_clk[2].wa)
    else $error("receive fifo write not on lane recovered strobe");

  COV_X4_HALF: cover property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X4 && lane_clk[3].txf_rd && $past(cfg.byte_ser));

  COV_X2_ALT: cover property (@(posedge core_clk) disable iff (reset)
    st_reg.bond_prev == BLCD_BOND_X2 && $past(cfg.alt_src) && fabric_clk_tick);

  COV_RM: cover property (@(posedge core_clk) disable iff (reset)
    lane_clk[2].rmf_rd ##[1:20] lane_clk[2].rxf_wr);

  COV_REGROUP: cover property (@(posedge core_clk) disable iff (reset)
    st_next.bond_prev != st_reg.bond_prev);

  COV_RX_HALF: cover property (@(posedge core_clk) disable iff (reset)
    lane_clk[2].rxf_wr && $past(cfg.byte_deser));

endmodule : blcd_top
`default_nettype wire

// file: bonded_lane_clock_distribution_test.sv
`timescale 1ns/100ps
`default_nettype none
module bonded_lane_clock_distribution_test;
  import blcd_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  localparam logic [NUM_TICKS-1:0] M_A   = 11'h001;
  localparam logic [NUM_TICKS-1:0] M_B   = 11'h002;
  localparam logic [NUM_TICKS-1:0] M_G   = 11'h004;
  localparam logic [NUM_TICKS-1:0] M_RLS = 11'h078;
  localparam logic [NUM_TICKS-1:0] M_RHS = 11'h780;
  localparam blcd_lane_clk_t TXS = 12'h700;
  localparam blcd_lane_clk_t SER = 12'h800;
  localparam blcd_lane_clk_t DES = 12'h080;
  localparam blcd_lane_clk_t RXO = 12'h04F;
  localparam blcd_lane_clk_t RML = 12'h060;
  localparam blcd_lane_clk_t RMS = 12'h01F;

  logic                            core_clk = 1'b0;
  logic                            reset    = 1'b1;
  blcd_cfg_t                       cfg      = '0;
  logic [NUM_TICKS-1:0]            src_mask = '0;
  logic                            fire     = 1'b0;
  logic                            clr      = 1'b1;
  logic [NUM_TICKS-1:0]            src_lvl;
  logic [7:0]                      fab_cnt;
  blcd_lane_clk_t [NUM_LANES-1:0]  lane_clk;
  blcd_lane_clk_t [NUM_LANES-1:0]  hit;
  logic [NUM_LANES-1:0][PTR_W-1:0] lane_fifo_ptr;
  logic                            fabric_clk_tick;
  logic [7:0]                      txf_cnt;
  logic [7:0]                      rxf_cnt;
  int                              mismatches = 0;
  int                              cmp_count  = 0;

  always #4 core_clk = ~core_clk;

  blcd_top i_dut (
    .core_clk        (core_clk),
    .reset           (reset),
    .cfg             (cfg),
    .adjacent_pll_a  (src_lvl[TICK_PLL_A]),
    .adjacent_pll_b  (src_lvl[TICK_PLL_B]),
    .general_pll_one (src_lvl[TICK_GEN]),
    .rec_ls_clk      (src_lvl[TICK_REC_LS +: NUM_LANES]),
    .rec_hs_clk      (src_lvl[TICK_REC_HS +: NUM_LANES]),
    .lane_clk        (lane_clk),
    .lane_fifo_ptr   (lane_fifo_ptr),
    .fabric_clk_tick (fabric_clk_tick)
  );

  blcd_fabric_model i_fabric (
    .core_clk        (core_clk),
    .src_mask        (src_mask),
    .fire            (fire),
    .clr             (clr),
    .fabric_clk_tick (fabric_clk_tick),
    .src_lvl         (src_lvl),
    .fab_cnt         (fab_cnt)
  );

  // strobes are one cycle wide, so collect them rather than sample once
  always @(posedge core_clk) begin
    hit     <= clr ? '0 : (hit | lane_clk);
    txf_cnt <= clr ? 8'h00 : txf_cnt + {7'h00, lane_clk[0].txf_rd};
    rxf_cnt <= clr ? 8'h00 : rxf_cnt + {7'h00, lane_clk[0].rxf_wr};
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic close_out;
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic do_reset;
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
  endtask : do_reset

  // f = {rate_match, byte_ser, byte_deser, shared_sel, alt_src}
  task automatic set_cfg(input blcd_bond_t b, input blcd_op_t o, input logic [4:0] f,
                         input logic [3:0] hs, input logic [3:0] ls);
    @(posedge core_clk);
    cfg <= '{bond: b, op: o, rate_match: f[4], byte_ser: f[3], byte_deser: f[2],
             shared_sel: f[1], alt_src: f[0], hs_sel: hs, lane_ls_sel: ls};
  endtask : set_cfg

  task automatic fire_src(input logic [NUM_TICKS-1:0] m, input int n);
    @(posedge core_clk);
    clr      <= 1'b1;
    src_mask <= m;
    @(posedge core_clk);
    clr  <= 1'b0;
    fire <= 1'b1;
    repeat (6 * n) @(posedge core_clk);
    fire <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : fire_src

  task automatic check_lanes(input logic [3:0] sm, input blcd_lane_clk_t sv,
                             input logic [3:0] hm, input blcd_lane_clk_t hv,
                             input logic [7:0] fab);
    for (int l = 0; l < NUM_LANES; l++) begin
      chk(hit[l], (sm[l] ? sv : 12'h000) | (hm[l] ? hv : 12'h000));
    end
    chk(12'(fab_cnt), 12'(fab));
  endtask : check_lanes

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    set_cfg(BLCD_BOND_X4, BLCD_OP_TX_ONLY, 5'h00, 4'h5, 4'h0);
    fire_src(M_A, 1);
    check_lanes(4'hF, TXS, 4'hA, SER, 8'h01);
    fire_src(M_B, 1);
    check_lanes(4'h0, TXS, 4'h5, SER, 8'h00);
    set_cfg(BLCD_BOND_X4, BLCD_OP_TX_ONLY, 5'h02, 4'h5, 4'h0);
    fire_src(M_B, 1);
    check_lanes(4'hF, TXS, 4'h5, SER, 8'h01);
    set_cfg(BLCD_BOND_X4, BLCD_OP_RX_ONLY, 5'h00, 4'h0, 4'h0);
    fire_src(M_A | M_RLS | M_RHS, 1);
    check_lanes(4'hF, RXO | DES, 4'h0, SER, 8'h00);
    set_cfg(BLCD_BOND_X4, BLCD_OP_TX_RX, 5'h10, 4'h0, 4'h0);
    fire_src(M_RLS | M_RHS, 1);
    check_lanes(4'hF, RML | DES, 4'h0, SER, 8'h00);
    fire_src(M_A, 1);
    check_lanes(4'hF, TXS | RMS, 4'hF, SER, 8'h01);
    set_cfg(BLCD_BOND_X4, BLCD_OP_TX_RX, 5'h00, 4'h0, 4'h0);
    fire_src(M_RLS, 1);
    check_lanes(4'hF, RXO, 4'h0, SER, 8'h00);
    fire_src(M_A, 1);
    check_lanes(4'hF, TXS, 4'hF, SER, 8'h01);
    set_cfg(BLCD_BOND_X2, BLCD_OP_TX_ONLY, 5'h00, 4'h0, 4'hC);
    fire_src(M_A, 1);
    check_lanes(4'h3, TXS, 4'hF, SER, 8'h01);
    fire_src(M_B, 1);
    check_lanes(4'hC, TXS, 4'h0, SER, 8'h00);
    set_cfg(BLCD_BOND_X2, BLCD_OP_TX_ONLY, 5'h01, 4'h0, 4'hC);
    fire_src(M_G, 1);
    check_lanes(4'h3, TXS, 4'h3, SER, 8'h01);
    fire_src(M_A, 1);
    check_lanes(4'h0, TXS, 4'hC, SER, 8'h00);
    // second reset so the dividers start from their known phase
    set_cfg(BLCD_BOND_X4, BLCD_OP_TX_ONLY, 5'h08, 4'h0, 4'h0);
    do_reset();
    fire_src(M_A, 2);
    chk(12'(txf_cnt), 12'h001);
    chk(12'(fab_cnt), 12'h002);
    for (int l = 0; l < NUM_LANES; l++) begin
      chk(12'(lane_fifo_ptr[l]), 12'h001);
    end
    set_cfg(BLCD_BOND_X2, BLCD_OP_TX_ONLY, 5'h08, 4'h0, 4'h0);
    repeat (3) @(posedge core_clk);
    chk(12'({lane_fifo_ptr[1], lane_fifo_ptr[0]}), 12'h000);
    set_cfg(BLCD_BOND_X4, BLCD_OP_TX_RX, 5'h1C, 4'h0, 4'h0);
    do_reset();
    fire_src(M_A, 2);
    chk(12'(rxf_cnt), 12'h001);
    chk(12'(txf_cnt), 12'h001);
    close_out();
  end

  // whole sequence is well under 1000 cycles
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
endmodule : bonded_lane_clock_distribution_test
`default_nettype wire
